/* File: include/trg_params.svh */
// constants of the transfer request generator
//=============================================================
// Overview of operation
// - every request carries source, destination, count and both address modes
// - cpu access to internal, control registers or on-chip sram issues nothing
// - uncached external access or uncached-l2 write l1 miss issues one element
// - l2 off, cacheable read miss issues one 64 byte l1 line request
// - l2 on, l2 miss fills the line with two 64 byte requests
// - access hitting an allocated line issues no request
// - dirty victim on allocation is written back with one request
// - quick dma write issues one block or frame request in one cycle
// - each channel event issues exactly one request from its parameter set
// - 1d/1d channel moves one element, or one frame when frame sync set
// - other channels move one array, or (arrays+1) times elements
// - host port holds eight word read and write fifos
// - host access without auto increment issues a one word request
// - auto increment read with empty read fifo issues eight words
// - auto read, fifo at most half, nothing outstanding issues four words
// - every fourth auto increment write issues four words
// - pci keeps 16 word buffers for each of four traffic kinds
// - pci slave access to non-prefetchable memory issues one word
// - pci prefetchable slave write over quarter full issues min(4, size)
// - pci slave read: empty buffer min(16,size), below 3/4 min(4,rest)
// - pci master write like slave read; master read over 1/4 issues min(4,rest)
// - mac has three 64 byte buffers each way, requests at most 16 words
`ifndef TRG_PARAMS_SVH
`define TRG_PARAMS_SVH
`define TRG_NSRC 6
`define TRG_ADDR_CTRL 4'h0
`define TRG_ADDR_STAT 4'h4
`define TRG_ADDR_CNT 4'h8
`define TRG_CTRL_L2EN 0
`define TRG_CTRL_RST 32'h00000000
`define TRG_LINE_OFS 7
`define TRG_L1_MASK 32'hffffffc0
`define TRG_HALF_BYTES 32'h00000040
`define TRG_ONE 32'h00000001
`define TRG_L1_WORDS 32'h00000010
`define TRG_HALF_WORDS 32'h00000010
`define TRG_LINE_WORDS 32'h00000020
`define TRG_HOST_BURST 32'h00000008
`define TRG_HOST_QUAD 32'h00000004
`define TRG_HOST_HALF 4'h4
`define TRG_HOST_LAST 2'h3
`define TRG_PCI_BURST 32'h00000010
`define TRG_PCI_QUAD 32'h00000004
`define TRG_PCI_QTR 5'h04
`define TRG_PCI_3QTR 5'h0c
`define TRG_MAC_MAX 32'h00000010
`define TRG_ID_MAC 3'h5
`endif

/* File: include/trg_pkg.sv */
// types of the transfer request generator
package trg_pkg;
	typedef enum logic [1:0] {TRG_FIXED, TRG_INCR, TRG_DECR, TRG_INDEX} trg_mode_t;
	typedef struct packed {
		logic [31:0] src;
		logic [31:0] dst;
		logic [31:0] cnt;
		trg_mode_t srcMode;
		trg_mode_t dstMode;
	} trg_desc_t;
	typedef enum logic [2:0] {TRG_RG_INTREG, TRG_RG_CFGREG, TRG_RG_SRAM, TRG_RG_EXT_NC, TRG_RG_EXT_C} trg_region_t;
	typedef struct packed {
		trg_region_t region;
		logic write;
		logic l1Hit;
		logic [31:0] addr;
	} trg_cpu_t;
	typedef struct packed {
		trg_desc_t base;
		logic [15:0] elemCnt;
		logic [15:0] arrCnt;
		logic oneDim;
		logic frameSyncSelect;
	} trg_chan_t;
	typedef enum logic [1:0] {TRG_PCI_SLV_RD, TRG_PCI_SLV_WR, TRG_PCI_MST_RD, TRG_PCI_MST_WR} trg_pcikind_t;
	typedef struct packed {
		trg_pcikind_t kind;
		logic pref;
		logic [4:0] lvl;
		logic [31:0] rem;
	} trg_pciacc_t;
endpackage

/* File: rtl/trg_request_gen.sv */
// transfer request generation for cache, quick dma, channels, host, pci and mac
`timescale 1ns/1ps
`default_nettype none
`include "trg_params.svh"
module trg_request_gen #(
	parameter int NCH = 4,
	parameter int L2_SETS = 4,
	parameter int HOST_FIFO_WORDS = 8,
	parameter int PCI_BUF_WORDS = 16
) (
	// clock and reset
	input wire logic mclk,
	input wire logic sys_rst,
	// register port
	input wire logic [3:0] regAddr,
	input wire logic [31:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	output logic [31:0] regRdata,
	// cpu access to the cache controller
	input wire logic cpuReq,
	input wire trg_pkg::trg_cpu_t cpuAcc,
	output logic cpuReady,
	// quick dma request
	input wire logic qdmaWr,
	input wire trg_pkg::trg_desc_t qdmaDesc,
	output logic qdmaReady,
	// channel events and parameter sets
	input wire logic [NCH-1:0] chEvent,
	input wire trg_pkg::trg_chan_t [NCH-1:0] chParam,
	// host port
	input wire logic hostAcc,
	input wire logic hostWrite,
	input wire logic hostAutoInc,
	input wire trg_pkg::trg_desc_t hostDesc,
	output logic hostReady,
	output logic [3:0] hostRdLevel,
	output logic [1:0] hostWrCount,
	// pci port
	input wire logic pciAcc,
	input wire trg_pkg::trg_pciacc_t pciInfo,
	input wire trg_pkg::trg_desc_t pciDesc,
	output logic pciReady,
	// ethernet mac requestor
	input wire logic emacReq,
	input wire trg_pkg::trg_desc_t emacDesc,
	output logic emacReady,
	// transfer request bus
	output logic trValid,
	input wire logic trReady,
	output trg_pkg::trg_desc_t trOut,
	output logic [2:0] trSrc
);
	import trg_pkg::*;
	localparam int IDXW = $clog2(L2_SETS);
	localparam int TAGW = 32 - `TRG_LINE_OFS - IDXW;
	localparam logic [`TRG_NSRC-1:0] ONE_S = {{(`TRG_NSRC-1){1'b0}}, 1'b1};
	localparam logic [NCH-1:0] ONE_C = {{(NCH-1){1'b0}}, 1'b1};
	typedef enum logic [1:0] {TRG_L2_IDLE, TRG_L2_FILL0, TRG_L2_FILL1} trg_l2st_t;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);

	// builds a contiguous request
	function automatic trg_desc_t mkDesc(input logic [31:0] a, input logic [31:0] n, input trg_mode_t m);
		trg_desc_t d;
		d.src = a;
		d.dst = a;
		d.cnt = n;
		d.srcMode = m;
		d.dstMode = m;
		return d;
	endfunction

	// request size of one channel event
	function automatic logic [31:0] chCount(input trg_chan_t p);
		logic [31:0] n;
		n = {16'h0000, p.elemCnt};
		if (p.oneDim && !p.frameSyncSelect)
			n = `TRG_ONE;
		else if (!p.oneDim && p.frameSyncSelect)
			n = ({16'h0000, p.arrCnt} + `TRG_ONE) * {16'h0000, p.elemCnt};
		return n;
	endfunction

	// smaller of a remaining size and a burst
	function automatic logic [31:0] capTo(input logic [31:0] r, input logic [31:0] b);
		return (r < b) ? r : b;
	endfunction

	//=============================================================
	// request slots and state
	//=============================================================
	logic [31:0] ctrl_r, trCnt_r, regRdata_r;
	logic [`TRG_NSRC-1:0] pend_r, ld, lowP, grant;
	trg_desc_t desc_r [`TRG_NSRC];
	trg_desc_t newDesc [`TRG_NSRC];
	trg_desc_t selDesc, out_r;
	logic [2:0] selId, trSrc_r;
	logic outValid_r, take;
	trg_l2st_t l2St_r, l2St_nxt;
	logic [31:0] lineAddr_r;
	logic [TAGW-1:0] tag_r [L2_SETS];
	logic [L2_SETS-1:0] vld_r, dirty_r;
	logic [NCH-1:0] evt_r, lowE;
	logic [3:0] rdLvl_r;
	logic [1:0] wrCnt_r;
	logic hostRd_r;

	//=============================================================
	// cache controller decode
	//=============================================================
	wire [IDXW-1:0] idx = cpuAcc.addr[`TRG_LINE_OFS +: IDXW];
	wire [TAGW-1:0] tagIn = cpuAcc.addr[31 -: TAGW];
	wire l2En = ctrl_r[`TRG_CTRL_L2EN];
	wire cpuTake = cpuReq & cpuReady;
	wire isExtC = cpuAcc.region == TRG_RG_EXT_C;
	wire l2Hit = vld_r[idx] & (tag_r[idx] == tagIn);
	wire ncSingle = (cpuAcc.region == TRG_RG_EXT_NC) | (isExtC & !l2En & cpuAcc.write & !cpuAcc.l1Hit);
	wire l1Fill = isExtC & !l2En & !cpuAcc.write & !cpuAcc.l1Hit;
	wire l2Miss = isExtC & l2En & !cpuAcc.l1Hit & !l2Hit;
	wire wbNeed = l2Miss & vld_r[idx] & dirty_r[idx];
	wire [31:0] lineIn = {cpuAcc.addr[31:`TRG_LINE_OFS], {`TRG_LINE_OFS{1'b0}}};
	wire [31:0] victim = {tag_r[idx], idx, {`TRG_LINE_OFS{1'b0}}};
	assign cpuReady = (l2St_r == TRG_L2_IDLE) & !pend_r[0];

	// slot 0 loads from the cache controller
	// local spaces issue nothing
	assign ld[0] = (cpuTake & (ncSingle | l1Fill | l2Miss)) | ((l2St_r != TRG_L2_IDLE) & !pend_r[0]);
	always_comb
	begin
		l2St_nxt = l2St_r;
		newDesc[0] = mkDesc(lineAddr_r, `TRG_HALF_WORDS, TRG_INCR);
		unique case (l2St_r)
			TRG_L2_IDLE:
			begin
				if (ncSingle)
					newDesc[0] = mkDesc(cpuAcc.addr, `TRG_ONE, TRG_FIXED);
				else if (l1Fill)
					newDesc[0] = mkDesc(cpuAcc.addr & `TRG_L1_MASK, `TRG_L1_WORDS, TRG_INCR);
				else if (wbNeed)
					newDesc[0] = mkDesc(victim, `TRG_LINE_WORDS, TRG_INCR);
				else
					newDesc[0] = mkDesc(lineIn, `TRG_HALF_WORDS, TRG_INCR);
				if (cpuTake && l2Miss)
					l2St_nxt = wbNeed ? TRG_L2_FILL0 : TRG_L2_FILL1;
			end
			TRG_L2_FILL0:
				if (!pend_r[0])
					l2St_nxt = TRG_L2_FILL1;
			TRG_L2_FILL1:
			begin
				newDesc[0] = mkDesc(lineAddr_r + `TRG_HALF_BYTES, `TRG_HALF_WORDS, TRG_INCR);
				if (!pend_r[0])
					l2St_nxt = TRG_L2_IDLE;
			end
		endcase
	end

	// cache state and line tags
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			l2St_r <= TRG_L2_IDLE;
			lineAddr_r <= 32'h00000000;
			vld_r <= '0;
			dirty_r <= '0;
			for (int i = 0; i < L2_SETS; i++)
				tag_r[i] <= '0;
		end
		else
		begin
			l2St_r <= l2St_nxt;
			if (cpuTake && l2Miss)
			begin
				lineAddr_r <= lineIn;
				tag_r[idx] <= tagIn;
				vld_r[idx] <= 1'b1;
				dirty_r[idx] <= cpuAcc.write;
			end
			// hits stay local, writes that miss l1 mark the line
			else if (cpuTake && isExtC && l2En && !cpuAcc.l1Hit && cpuAcc.write)
				dirty_r[idx] <= 1'b1;
		end
	end

	a_local_no_tr: assert property (cpuTake && cpuAcc.region < TRG_RG_EXT_NC |-> !ld[0])
		else $error("local access produced a request");
	a_single_elem: assert property (cpuTake && cpuAcc.region == TRG_RG_EXT_NC |=> pend_r[0] && desc_r[0].cnt == 1)
		else $error("uncached access not a single element");
	a_l1_line: assert property (cpuTake && l1Fill |=> desc_r[0].cnt == 16 && desc_r[0].src[5:0] == 0)
		else $error("l1 fill size wrong");
	a_l2_two_fills: assert property (cpuTake && l2Miss && !wbNeed |=> l2St_r == TRG_L2_FILL1 && desc_r[0].cnt == 16)
		else $error("l2 fill not split in halves");
	a_hit_local: assert property (cpuTake && isExtC && l2En && l2Hit |-> !ld[0])
		else $error("hit produced a request");
	a_wb_first: assert property (cpuTake && wbNeed |=> desc_r[0].cnt == 32 && l2St_r == TRG_L2_FILL0)
		else $error("dirty victim not written back");
	c_wb_seen: cover property (cpuTake && wbNeed ##[1:20] l2St_r == TRG_L2_IDLE);

	//=============================================================
	// quick dma and channel events
	//=============================================================
	// quick dma lands in its slot in one cycle
	assign qdmaReady = !pend_r[1];
	assign ld[1] = qdmaWr & qdmaReady;
	assign newDesc[1] = qdmaDesc;
	a_quick_dma_request_fast: assert property (qdmaWr && qdmaReady |=> pend_r[1] && desc_r[1] == $past(qdmaDesc))
		else $error("quick dma not taken in one cycle");

	// one request per latched event, lowest channel first
	assign lowE = evt_r & (~evt_r + ONE_C);
	assign ld[2] = (|evt_r) & !pend_r[2];
	always_comb
	begin
		newDesc[2] = chParam[0].base;
		for (int i = 0; i < NCH; i++)
			if (lowE[i])
			begin
				newDesc[2] = chParam[i].base;
				// size from dimensions and frame sync
				newDesc[2].cnt = chCount(chParam[i]);
			end
	end
	// a new event wins over the clear of the same channel
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
			evt_r <= '0;
		else
			evt_r <= (evt_r & ~(ld[2] ? lowE : '0)) | chEvent;
	end

	//=============================================================
	// host port
	//=============================================================
	wire hostAutoRd = hostAutoInc & !hostWrite;
	wire hostTake = hostAcc & hostReady;
	wire hostPop = hostTake & hostAutoRd & (rdLvl_r != 4'h0);
	wire hostFill = grant[3] & hostRd_r;
	assign hostReady = !pend_r[3] | (hostAutoRd & rdLvl_r != 4'h0) | (hostAutoInc & hostWrite & wrCnt_r != `TRG_HOST_LAST);
	assign ld[3] = hostTake & (!hostAutoInc | (hostAutoRd & (rdLvl_r == 4'h0 | (rdLvl_r <= `TRG_HOST_HALF & !pend_r[3])))
		| (hostAutoInc & hostWrite & wrCnt_r == `TRG_HOST_LAST));
	always_comb
	begin
		newDesc[3] = hostDesc;
		// single word when not auto incrementing
		newDesc[3].cnt = `TRG_ONE;
		if (hostAutoRd && rdLvl_r == 4'h0)
			newDesc[3].cnt = `TRG_HOST_BURST;
		// half empty read or fourth write moves four
		else if (hostAutoInc)
			newDesc[3].cnt = `TRG_HOST_QUAD;
	end
	// read fifo level and write grouping
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			rdLvl_r <= 4'h0;
			wrCnt_r <= 2'h0;
			hostRd_r <= 1'b0;
		end
		else
		begin
			rdLvl_r <= rdLvl_r + (hostFill ? desc_r[3].cnt[3:0] : 4'h0) - (hostPop ? 4'h1 : 4'h0);
			if (hostTake && hostAutoInc && hostWrite)
				wrCnt_r <= wrCnt_r + 2'h1;
			// single word reads go straight to the host, only auto reads refill the fifo
			if (ld[3])
				hostRd_r <= hostAutoRd;
		end
	end
	assign hostRdLevel = rdLvl_r;
	assign hostWrCount = wrCnt_r;
	a_host_burst: assert property (hostTake && hostAutoRd && rdLvl_r == 0 |=> desc_r[3].cnt == HOST_FIFO_WORDS)
		else $error("empty fifo read not eight words");
	c_host_wr4: cover property (hostTake && hostAutoInc && hostWrite && wrCnt_r == `TRG_HOST_LAST);
	a_host_fifo_cap: assert property (rdLvl_r <= HOST_FIFO_WORDS)
		else $error("host read fifo over eight words");

	//=============================================================
	// pci port
	//=============================================================
	// buffer levels count up to the 16 word buffers
	wire [31:0] pciQuad = capTo(pciInfo.rem, `TRG_PCI_QUAD);
	wire [31:0] pciBurst = capTo(pciInfo.rem, `TRG_PCI_BURST);
	wire pciSlave = (pciInfo.kind == TRG_PCI_SLV_RD) | (pciInfo.kind == TRG_PCI_SLV_WR);
	wire pciFirstKind = (pciInfo.kind == TRG_PCI_SLV_RD) | (pciInfo.kind == TRG_PCI_MST_WR);
	wire pciOverQtr = pciInfo.lvl > `TRG_PCI_QTR;
	wire pciEmpty = pciInfo.lvl == 5'h00;
	// non-prefetchable slave access moves one word
	wire pciOne = pciSlave & !pciInfo.pref;
	wire pciFirst = !pciOne & pciFirstKind & pciEmpty;
	wire pciLater = !pciOne & pciFirstKind & !pciEmpty & (pciInfo.lvl < `TRG_PCI_3QTR);
	// drain side once over a quarter
	wire pciDrain = !pciOne & !pciFirstKind & pciOverQtr;
	assign pciReady = !pend_r[4];
	assign ld[4] = pciAcc & pciReady & (pciOne | pciFirst | pciLater | pciDrain);
	always_comb
	begin
		newDesc[4] = pciDesc;
		newDesc[4].cnt = pciOne ? `TRG_ONE : (pciFirst ? pciBurst : pciQuad);
	end
	c_pci_first: cover property (ld[4] && pciFirst ##1 desc_r[4].cnt == PCI_BUF_WORDS);

	//=============================================================
	// ethernet mac
	//=============================================================
	// requests clipped to one 64 byte buffer
	assign emacReady = !pend_r[5];
	assign ld[5] = emacReq & emacReady;
	always_comb
	begin
		newDesc[5] = emacDesc;
		newDesc[5].cnt = capTo(emacDesc.cnt, `TRG_MAC_MAX);
	end

	//=============================================================
	// slots and request bus output
	//=============================================================
	// each slot holds a full descriptor until granted
	genvar s;
	generate
		for (s = 0; s < `TRG_NSRC; s++)
		begin : g_slot
			always_ff @(posedge mclk or posedge sys_rst)
			begin
				if (sys_rst)
				begin
					pend_r[s] <= 1'b0;
					desc_r[s] <= '0;
				end
				else
				begin
					pend_r[s] <= ld[s] | (pend_r[s] & !grant[s]);
					if (ld[s])
						desc_r[s] <= newDesc[s];
				end
			end
		end
	endgenerate

	// lowest pending slot wins the bus
	assign take = !outValid_r | trReady;
	assign lowP = pend_r & (~pend_r + ONE_S);
	assign grant = take ? lowP : '0;
	always_comb
	begin
		selDesc = desc_r[0];
		selId = 3'h0;
		for (int i = 0; i < `TRG_NSRC; i++)
			if (lowP[i])
			begin
				selDesc = desc_r[i];
				selId = 3'(i);
			end
	end
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			outValid_r <= 1'b0;
			out_r <= '0;
			trSrc_r <= 3'h0;
		end
		else if (take)
		begin
			outValid_r <= |pend_r;
			out_r <= selDesc;
			trSrc_r <= selId;
		end
	end
	assign trValid = outValid_r;
	assign trOut = out_r;
	assign trSrc = trSrc_r;
	a_mac_cap: assert property (trValid && trSrc == `TRG_ID_MAC |-> trOut.cnt <= 16)
		else $error("mac request over 16 words");
	a_out_hold: assert property (trValid && !trReady |=> trValid && $stable(trOut))
		else $error("request changed before taken");

	//=============================================================
	// register port
	//=============================================================
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			ctrl_r <= `TRG_CTRL_RST;
			trCnt_r <= 32'h00000000;
			regRdata_r <= 32'h00000000;
		end
		else
		begin
			if (regWr && regAddr == `TRG_ADDR_CTRL)
				ctrl_r <= regWdata;
			if (trValid && trReady)
				trCnt_r <= trCnt_r + 32'h00000001;
			unique case (1'b1)
				regRd && regAddr == `TRG_ADDR_CTRL: regRdata_r <= ctrl_r;
				regRd && regAddr == `TRG_ADDR_STAT: regRdata_r <= {20'h00000, rdLvl_r, l2St_r, pend_r};
				regRd && regAddr == `TRG_ADDR_CNT: regRdata_r <= trCnt_r;
				default: regRdata_r <= 32'h00000000;
			endcase
		end
	end
	assign regRdata = regRdata_r;
endmodule
`default_nettype wire

/* File: testbench/trg_request_gen_tb.sv */
// self-checking bench of the transfer request generator
`timescale 1ns/1ps
`default_nettype none
module trg_request_gen_tb;
	import trg_pkg::*;
	//=========================================================
	// signals
	logic mclk = 0;
	logic sys_rst = 1;
	logic [3:0] regAddr;
	logic [31:0] regWdata, regRdata;
	logic regWr, regRd, cpuReq, cpuReady, qdmaWr, qdmaReady;
	trg_cpu_t cpuAcc;
	trg_desc_t qdmaDesc, hostDesc, pciDesc, emacDesc, trOut, d;
	logic [3:0] chEvent;
	trg_chan_t [3:0] chParam;
	logic hostAcc, hostWrite, hostAutoInc, hostReady;
	logic [3:0] hostRdLevel;
	logic [1:0] hostWrCount;
	logic pciAcc, pciReady, emacReq, emacReady, trValid, trReady, slowMode;
	trg_pciacc_t pciInfo;
	logic [2:0] trSrc;
	int fail_count = 0;
	int num_checks = 0;
	trg_desc_t gotQ[$];
	logic [2:0] srcQ[$];
	//=========================================================
	// design, partner, clock
	trg_request_gen #(.NCH(4)) dut (.mclk(mclk), .sys_rst(sys_rst), .regAddr(regAddr),
		.regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .cpuReq(cpuReq),
		.cpuAcc(cpuAcc), .cpuReady(cpuReady), .qdmaWr(qdmaWr), .qdmaDesc(qdmaDesc),
		.qdmaReady(qdmaReady), .chEvent(chEvent), .chParam(chParam), .hostAcc(hostAcc),
		.hostWrite(hostWrite), .hostAutoInc(hostAutoInc), .hostDesc(hostDesc),
		.hostReady(hostReady), .hostRdLevel(hostRdLevel), .hostWrCount(hostWrCount),
		.pciAcc(pciAcc), .pciInfo(pciInfo), .pciDesc(pciDesc), .pciReady(pciReady),
		.emacReq(emacReq), .emacDesc(emacDesc), .emacReady(emacReady), .trValid(trValid),
		.trReady(trReady), .trOut(trOut), .trSrc(trSrc));
	trg_tc_model tc (.mclk(mclk), .sys_rst(sys_rst), .trValid(trValid), .slowMode(slowMode),
		.trReady(trReady));
	always #4 mclk = ~mclk;
	// record every request the bus accepts
	always @(posedge mclk)
	begin
		if (trValid === 1'b1 && trReady === 1'b1)
		begin
			gotQ.push_back(trOut);
			srcQ.push_back(trSrc);
		end
	end
	//=========================================================
	// shared tasks
	task chk(input logic [127:0] s, input logic [127:0] e);
		num_checks++;
		if (s !== e)
		begin
			fail_count++;
			$display("[FAIL] %0t seen %0h expected %0h", $time, s, e);
		end
	endtask
	task close_out;
		if (fail_count == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task drain;
		repeat (40) @(posedge mclk);
	endtask
	task clr;
		gotQ.delete();
		srcQ.delete();
	endtask
	task rw(input logic [3:0] a, input logic [31:0] v);
		regAddr <= a;
		regWdata <= v;
		regWr <= 1;
		@(posedge mclk);
		regWr <= 0;
	endtask
	task rr(input logic [3:0] a, input logic [31:0] e);
		regAddr <= a;
		regRd <= 1;
		@(posedge mclk);
		regRd <= 0;
		#1 chk(regRdata, e);
		@(posedge mclk);
	endtask
	task cpu(input trg_region_t r, input logic w, input logic [31:0] a, input logic h = 1'b0);
		cpuAcc <= '{r, w, h, a};
		cpuReq <= 1;
		do @(posedge mclk); while (cpuReady !== 1'b1);
		cpuReq <= 0;
		drain();
	endtask
	task host(input logic w, input logic ai);
		hostWrite <= w;
		hostAutoInc <= ai;
		hostAcc <= 1;
		do @(posedge mclk); while (hostReady !== 1'b1);
		hostAcc <= 0;
		drain();
	endtask
	//=========================================================
	// scenarios
	task t_regs;
		rr(4'h0, 32'h0);
		rr(4'hc, 32'h0);
		rw(4'h0, 32'h1);
		rr(4'h0, 32'h1);
		rw(4'h0, 32'h0);
	endtask
	task t_cpu_flat;
		clr();
		cpu(TRG_RG_INTREG, 0, 32'h100);
		cpu(TRG_RG_CFGREG, 1, 32'h200);
		cpu(TRG_RG_SRAM, 0, 32'h300);
		cpu(TRG_RG_EXT_C, 1, 32'h80000040, 1'b1);
		cpu(TRG_RG_EXT_C, 0, 32'h80000040, 1'b1);
		chk(gotQ.size(), 0);
		cpu(TRG_RG_EXT_NC, 0, 32'h80000010);
		cpu(TRG_RG_EXT_C, 1, 32'h80000020);
		cpu(TRG_RG_EXT_C, 0, 32'h80000030);
		chk(gotQ.size(), 3);
		chk(gotQ[0].cnt, 1);
		chk(gotQ[1].cnt, 1);
		chk(gotQ[2].cnt, 16);
		chk(srcQ[0], 0);
	endtask
	task t_cpu_l2;
		rw(4'h0, 32'h1);
		clr();
		cpu(TRG_RG_EXT_C, 0, 32'h80000000);
		chk(gotQ.size(), 2);
		chk(gotQ[0].cnt, 16);
		chk(gotQ[1].cnt, 16);
		chk(gotQ[1].src - gotQ[0].src, 32'h40);
		clr();
		cpu(TRG_RG_EXT_C, 0, 32'h80000004);
		cpu(TRG_RG_EXT_C, 1, 32'h80000008);
		chk(gotQ.size(), 0);
		// same set, other line: dirty occupant goes out first
		cpu(TRG_RG_EXT_C, 0, 32'h80000200);
		chk(gotQ.size(), 3);
		chk(gotQ[0].cnt, 32);
		chk(gotQ[2].cnt, 16);
		rw(4'h0, 32'h0);
	endtask
	task t_quick_dma_request;
		for (int m = 0; m < 4; m++)
		begin
			clr();
			d = '{32'h1000 + m, 32'h2000, 32'h40, trg_mode_t'(m), trg_mode_t'(3 - m)};
			qdmaDesc <= d;
			qdmaWr <= 1;
			do @(posedge mclk); while (qdmaReady !== 1'b1);
			qdmaWr <= 0;
			drain();
			chk(gotQ.size(), 1);
			chk(gotQ[0], d);
			chk(srcQ[0], 1);
		end
	endtask
	task automatic t_chan;
		int e[4] = '{1, 5, 6, 18};
		clr();
		chEvent <= 4'hf;
		@(posedge mclk);
		chEvent <= 4'h0;
		drain();
		chk(gotQ.size(), 4);
		for (int i = 0; i < 4; i++)
		begin
			chk(gotQ[i].cnt, e[i]);
			chk(srcQ[i], 2);
		end
	endtask
	task t_host;
		clr();
		host(0, 0);
		host(1, 0);
		chk(gotQ.size(), 2);
		chk(gotQ[1].cnt, 1);
		chk(srcQ[0], 3);
		clr();
		host(0, 1);
		chk(gotQ[0].cnt, 8);
		chk(hostRdLevel, 8);
		clr();
		for (int i = 0; i < 12 && hostRdLevel > 4; i++) host(0, 1);
		host(0, 1);
		chk(gotQ.size(), 1);
		chk(gotQ[0].cnt, 4);
		clr();
		repeat (3) host(1, 1);
		chk(gotQ.size(), 0);
		chk(hostWrCount, 3);
		host(1, 1);
		chk(gotQ[0].cnt, 4);
	endtask
	task automatic t_pci;
		int k[13] = '{0, 2, 3, 3, 3, 1, 1, 1, 1, 7, 7, 5, 5};
		int l[13] = '{0, 0, 5, 5, 4, 0, 0, 8, 12, 0, 8, 5, 4};
		int r[13] = '{10, 10, 10, 2, 10, 20, 9, 3, 10, 30, 10, 10, 10};
		int x[13] = '{1, 1, 4, 2, 0, 16, 9, 3, 0, 16, 4, 4, 0};
		for (int i = 0; i < 13; i++)
		begin
			clr();
			pciInfo <= '{trg_pcikind_t'(k[i] >> 1), k[i][0], l[i][4:0], r[i]};
			pciAcc <= 1;
			do @(posedge mclk); while (pciReady !== 1'b1);
			pciAcc <= 0;
			drain();
			chk(gotQ.size(), x[i] != 0);
			if (x[i] != 0)
				chk(gotQ[0].cnt, x[i]);
		end
	endtask
	task t_mac;
		slowMode <= 1;
		clr();
		for (int i = 0; i < 2; i++)
		begin
			emacDesc <= '{32'h3000, 32'h4000, i ? 32'h28 : 32'h8, TRG_INCR, TRG_INCR};
			emacReq <= 1;
			do @(posedge mclk); while (emacReady !== 1'b1);
			emacReq <= 0;
			drain();
		end
		chk(gotQ.size(), 2);
		chk(gotQ[0].cnt, 8);
		chk(gotQ[1].cnt, 16);
		chk(srcQ[1], 5);
		foreach (gotQ[i]) chk(gotQ[i].cnt <= 16, 1);
		slowMode <= 0;
	endtask
	//=========================================================
	// main sequence and watchdog
	initial
	begin
		{regAddr, regWdata, regWr, regRd, cpuReq, cpuAcc, qdmaWr, qdmaDesc} = '0;
		{chEvent, hostAcc, hostWrite, hostAutoInc, hostDesc, pciAcc, pciInfo} = '0;
		{pciDesc, emacReq, emacDesc, slowMode} = '0;
		for (int i = 0; i < 4; i++)
			chParam[i] = '{'{32'h5000, 32'h6000, 32'h0, TRG_INCR, TRG_INCR}, 16'h5 + 16'(i / 2),
				16'h2, i < 2, i[0]};
		repeat (10) @(posedge mclk);
		sys_rst <= 0;
		@(posedge mclk);
		t_regs();
		t_cpu_flat();
		t_cpu_l2();
		t_quick_dma_request();
		t_chan();
		t_host();
		t_pci();
		t_mac();
		close_out();
	end
	initial
	begin
		#200000;
		fail_count++;
		close_out();
	end
endmodule
`default_nettype wire

/* File: testbench/trg_tc_model.sv */
// request bus partner that takes requests at full rate or slowly
`timescale 1ns/1ps
`default_nettype none
module trg_tc_model
(
	// clock and reset
	input wire logic mclk,
	input wire logic sys_rst,
	// request bus
	input wire logic trValid,
	input wire logic slowMode,
	output logic trReady
);
	logic [1:0] phase_r;
	//=========================================================
	// acceptance pacing
	// phase counter runs while a request waits, slow mode takes it on the fourth cycle
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
			phase_r <= 2'h0;
		else if (trValid)
			phase_r <= phase_r + 2'h1;
	end
	// ready does not wait for valid, as a queue with space would
	assign trReady = !slowMode || (phase_r == 2'h3);
endmodule
`default_nettype wire
